// ===== include/pcr_pkg.sv
// Functional notes
// - Latency timer value sits in bits 15:8, counted in bus clocks.
// - Latency counter starts when the device drives its frame active.
// - Frame released before expiry: counter ignored, no termination.
// - After expiry, termination begins as soon as grant goes inactive.
// - I/O decode uses I/O base bits 31:7 plus register offset.
// - I/O base bit 0 reads 1, writes ignored.
// - Memory decode uses memory base bits 31:7 as base.
// - Memory base bit 0 reads 0, writes ignored.
// - Base bits 6:1 and ROM base bits 17:1 read zero.
// - After hardware reset subsystem ID is loaded from serial ROM.
// - Failed serial ROM integrity check leaves subsystem ID zero.
// - Subsystem ID in bits 31:16, subsystem vendor ID in 15:0.
// - ROM claimed only when memory enable and ROM enable both set.
// - Software reset leaves expansion ROM base unchanged.
// - Memory accesses answered only while command bit 1 set.
// - I/O accesses answered only while command bit 0 set.
package pcr_pkg;

    // Configuration offsets (byte addresses)
    localparam logic [7:0]  CFG_CMD_OFF  = 8'h04;
    localparam logic [7:0]  CFG_LAT_OFF  = 8'h0C;
    localparam logic [7:0]  CFG_IOB_OFF  = 8'h10;
    localparam logic [7:0]  CFG_MEMB_OFF = 8'h14;
    localparam logic [7:0]  CFG_SUBSYSTEM_IDENTIFICATION_OFF = 8'h2C;
    localparam logic [7:0]  CFG_ROMB_OFF = 8'h30;
    localparam logic [7:0]  CFG_INTR_OFF = 8'h3C;

    // Field positions
    localparam int          CMD_IO_BIT     = 0;
    localparam int          CMD_MEM_BIT    = 1;
    localparam int          CMD_MASTER_BIT = 2;
    localparam int          LAT_LSB        = 8;
    localparam int          CSR_BASE_LSB   = 7;
    localparam int          CSR_IDX_LSB    = 3;
    localparam int          ROM_BASE_LSB   = 18;
    localparam int          ROM_EN_BIT     = 0;

    // Writable bit masks
    localparam logic [31:0] CMD_WMASK  = 32'h0000_0147;
    localparam logic [31:0] LAT_WMASK  = 32'h0000_FF00;
    localparam logic [31:0] BAR_WMASK  = 32'hFFFF_FF80;
    localparam logic [31:0] ROM_WMASK  = 32'hFFFC_0001;
    localparam logic [31:0] INTR_WMASK = 32'h0000_00FF;

    // Fixed and reset values
    localparam logic [31:0] STATUS_FIXED  = 32'h0280_0000;
    localparam logic [31:0] CMD_RESET     = 32'h0000_0000;
    localparam logic [31:0] LAT_RESET     = 32'h0000_0000;
    localparam logic [31:0] BAR_RESET     = 32'h0000_0000;
    localparam logic [31:0] ROM_RESET     = 32'h0000_0000;
    localparam logic [31:0] INTR_RESET    = 32'h2814_0100;
    localparam logic [31:0] SUBSYSTEM_IDENTIFICATION_RESET    = 32'h0000_0000;
    localparam logic [31:0] IO_INDICATOR  = 32'h0000_0001;
    localparam logic [31:0] MEM_INDICATOR = 32'h0000_0000;

    // Latency timer states
    typedef enum logic [3:0] {
        LT_IDLE = 4'b0001,
        LT_RUN  = 4'b0010,
        LT_EXP  = 4'b0100,
        LT_END  = 4'b1000
    } pcr_lat_state_t;

endpackage : pcr_pkg

// ===== include/pcr_lat_if.sv
`timescale 1ns/10ps
// Latency timer link between register bank and counter
interface pcr_lat_if #(parameter int LAT_W = 8);
    logic [LAT_W-1:0] lat_value;
    logic             frame_drv;
    logic             gnt_n;
    logic             soft_rst;
    logic             terminate;
    logic             expired;

    modport regs  (output lat_value, output frame_drv, output gnt_n,
                   output soft_rst, input terminate, input expired);
    modport timer (input lat_value, input frame_drv, input gnt_n,
                   input soft_rst, output terminate, output expired);
endinterface : pcr_lat_if

// ===== verilog/pcr_lat_timer.sv
`timescale 1ns/10ps
module pcr_lat_timer
    import pcr_pkg::*;
#(
    parameter int LAT_W = 8
) (
    input  wire logic  i_ref_clk,
    input  wire logic  i_srst,
    pcr_lat_if.timer   lat
);

    initial begin
        if (LAT_W < 1 || LAT_W > 16) begin
            $error("pcr_lat_timer: LAT_W out of range");
        end
    end

    pcr_lat_state_t   state_q, state_d;
    logic [LAT_W-1:0] cnt_q, cnt_d;
    logic             term_q, term_d;
    logic             exp_q, exp_d;

    // Next state of the latency counter
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        unique case (state_q)
            LT_IDLE: begin
                if (lat.frame_drv) begin
                    cnt_d   = lat.lat_value;
                    state_d = (lat.lat_value == '0) ? LT_EXP : LT_RUN;
                end
            end
            LT_RUN: begin
                if (!lat.frame_drv) begin
                    state_d = LT_IDLE;
                end else if (cnt_q <= LAT_W'(1)) begin
                    cnt_d   = '0;
                    state_d = LT_EXP;
                end else begin
                    cnt_d = cnt_q - LAT_W'(1);
                end
            end
            LT_EXP: begin
                if (!lat.frame_drv) begin
                    state_d = LT_IDLE;
                end else if (lat.gnt_n) begin
                    state_d = LT_END;
                end
            end
            LT_END: begin
                if (!lat.frame_drv) begin
                    state_d = LT_IDLE;
                end
            end
            default: state_d = LT_IDLE;
        endcase
        if (lat.soft_rst) begin
            state_d = LT_IDLE;
        end
        term_d = (state_d == LT_END);
        exp_d  = (state_d == LT_EXP) || (state_d == LT_END);
    end

    // State registers
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            state_q <= LT_IDLE;
            cnt_q   <= '0;
            term_q  <= 1'b0;
            exp_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            term_q  <= term_d;
            exp_q   <= exp_d;
        end
    end

    assign lat.terminate = term_q;
    assign lat.expired   = exp_q;

endmodule : pcr_lat_timer

// ===== verilog/pcr_cfg_regs.sv
`timescale 1ns/10ps
module pcr_cfg_regs
    import pcr_pkg::*;
#(
    parameter int LAT_W = 8
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_srst,
    input  wire logic        i_soft_rst,
    // Configuration access port
    input  wire logic        i_cfg_sel,
    input  wire logic        i_cfg_we,
    input  wire logic [7:0]  i_cfg_addr,
    input  wire logic [3:0]  i_cfg_be,
    input  wire logic [31:0] i_cfg_wdata,
    output logic      [31:0] o_cfg_rdata,
    output logic             o_cfg_ack,
    // Serial ROM subsystem ID delivery
    input  wire logic        i_srom_valid,
    input  wire logic        i_srom_ok,
    input  wire logic [31:0] i_srom_data,
    // Target address decode
    input  wire logic        i_io_req,
    input  wire logic [31:0] i_io_addr,
    input  wire logic        i_mem_req,
    input  wire logic [31:0] i_mem_addr,
    output logic             o_io_hit,
    output logic             o_mem_hit,
    output logic             o_rom_hit,
    output logic      [3:0]  o_csr_index,
    // Bus master side
    input  wire logic        i_frame_drv,
    input  wire logic        i_gnt_n,
    output logic             o_master_en,
    output logic             o_lat_terminate,
    output logic             o_lat_expired
);

    initial begin
        if (LAT_W != 8) begin
            $error("pcr_cfg_regs: latency field is 8 bits wide");
        end
    end

    // Programmed state
    logic [31:0] cmd_q,  cmd_d;
    logic [31:0] lat_q,  lat_d;
    logic [31:0] iob_q,  iob_d;
    logic [31:0] memb_q, memb_d;
    logic [31:0] rom_q,  rom_d;
    logic [31:0] intr_q, intr_d;
    logic [31:0] subsystem_identification_q, subsystem_identification_d;
    logic        subsystem_identification_done_q, subsystem_identification_done_d;

    // Answer and decode state
    logic [31:0] rdata_q, rdata_d;
    logic        ack_q,   ack_d;
    logic        io_hit_q,  io_hit_d;
    logic        mem_hit_q, mem_hit_d;
    logic        rom_hit_q, rom_hit_d;
    logic [3:0]  idx_q,   idx_d;
    logic        master_q, master_d;

    // Byte lanes of a configuration write
    logic [31:0] be_mask;
    logic        wr_en;
    logic [31:0] rd_val;

    pcr_lat_if #(.LAT_W(LAT_W)) lat ();

    // Merge write data into writable bits only
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wdat,
                                          input logic [31:0] wmask);
        logic [31:0] m;
        m = wmask & be_mask;
        merge = (old & ~m) | (wdat & m);
    endfunction : merge

    // Byte enables widened to a bit mask
    always_comb begin
        be_mask = {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}},
                   {8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};
        wr_en   = i_cfg_sel && i_cfg_we;
    end

    // Configuration read view
    always_comb begin
        unique case (i_cfg_addr)
            CFG_CMD_OFF:  rd_val = STATUS_FIXED | (cmd_q & CMD_WMASK);
            CFG_LAT_OFF:  rd_val = lat_q & LAT_WMASK;
            CFG_IOB_OFF:  rd_val = (iob_q & BAR_WMASK) | IO_INDICATOR;
            CFG_MEMB_OFF: rd_val = (memb_q & BAR_WMASK) | MEM_INDICATOR;
            CFG_SUBSYSTEM_IDENTIFICATION_OFF: rd_val = subsystem_identification_q;
            CFG_ROMB_OFF: rd_val = rom_q & ROM_WMASK;
            CFG_INTR_OFF: rd_val = (INTR_RESET & ~INTR_WMASK)
                                   | (intr_q & INTR_WMASK);
            default:      rd_val = 32'h0000_0000;
        endcase
    end

    // Next values of the programmed registers
    always_comb begin
        cmd_d  = cmd_q;
        lat_d  = lat_q;
        iob_d  = iob_q;
        memb_d = memb_q;
        rom_d  = rom_q;
        intr_d = intr_q;
        if (wr_en) begin
            unique case (i_cfg_addr)
                CFG_CMD_OFF:  cmd_d  = merge(cmd_q,  i_cfg_wdata, CMD_WMASK);
                CFG_LAT_OFF:  lat_d  = merge(lat_q,  i_cfg_wdata, LAT_WMASK);
                CFG_IOB_OFF:  iob_d  = merge(iob_q,  i_cfg_wdata, BAR_WMASK);
                CFG_MEMB_OFF: memb_d = merge(memb_q, i_cfg_wdata, BAR_WMASK);
                CFG_ROMB_OFF: rom_d  = merge(rom_q,  i_cfg_wdata, ROM_WMASK);
                CFG_INTR_OFF: intr_d = merge(intr_q, i_cfg_wdata, INTR_WMASK);
                default:      cmd_d  = cmd_q;
            endcase
        end
    end

    // Programmed registers; soft reset touches none of them
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            cmd_q  <= CMD_RESET;
            lat_q  <= LAT_RESET;
            iob_q  <= BAR_RESET;
            memb_q <= BAR_RESET;
            rom_q  <= ROM_RESET;
            intr_q <= INTR_RESET;
        end else begin
            cmd_q  <= cmd_d;
            lat_q  <= lat_d;
            iob_q  <= iob_d;
            memb_q <= memb_d;
            rom_q  <= rom_d;
            intr_q <= intr_d;
        end
    end

    // Subsystem ID capture, once per hardware reset
    always_comb begin
        subsystem_identification_d      = subsystem_identification_q;
        subsystem_identification_done_d = subsystem_identification_done_q;
        if (!subsystem_identification_done_q && i_srom_valid) begin
            subsystem_identification_done_d = 1'b1;
            if (i_srom_ok) begin
                subsystem_identification_d = i_srom_data;
            end else begin
                subsystem_identification_d = SUBSYSTEM_IDENTIFICATION_RESET;
            end
        end
    end

    // Subsystem ID registers
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            subsystem_identification_q      <= SUBSYSTEM_IDENTIFICATION_RESET;
            subsystem_identification_done_q <= 1'b0;
        end else begin
            subsystem_identification_q      <= subsystem_identification_d;
            subsystem_identification_done_q <= subsystem_identification_done_d;
        end
    end

    // Configuration answer, one cycle after the access
    always_comb begin
        ack_d   = i_cfg_sel;
        rdata_d = (i_cfg_sel && !i_cfg_we) ? rd_val : 32'h0000_0000;
    end

    // Answer registers
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // Target decode of I/O, memory and expansion ROM spaces
    always_comb begin
        io_hit_d  = i_io_req && cmd_q[CMD_IO_BIT]
                    && (i_io_addr[31:CSR_BASE_LSB] == iob_q[31:CSR_BASE_LSB]);
        mem_hit_d = i_mem_req && cmd_q[CMD_MEM_BIT]
                    && (i_mem_addr[31:CSR_BASE_LSB] == memb_q[31:CSR_BASE_LSB]);
        rom_hit_d = i_mem_req && cmd_q[CMD_MEM_BIT] && rom_q[ROM_EN_BIT]
                    && (i_mem_addr[31:ROM_BASE_LSB] == rom_q[31:ROM_BASE_LSB]);
        if (io_hit_d) begin
            idx_d = i_io_addr[CSR_IDX_LSB+3:CSR_IDX_LSB];
        end else if (mem_hit_d) begin
            idx_d = i_mem_addr[CSR_IDX_LSB+3:CSR_IDX_LSB];
        end else begin
            idx_d = 4'h0;
        end
        if (i_soft_rst) begin
            io_hit_d  = 1'b0;
            mem_hit_d = 1'b0;
            rom_hit_d = 1'b0;
        end
        master_d = cmd_q[CMD_MASTER_BIT];
    end

    // Decode registers
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            io_hit_q  <= 1'b0;
            mem_hit_q <= 1'b0;
            rom_hit_q <= 1'b0;
            idx_q     <= 4'h0;
            master_q  <= 1'b0;
        end else begin
            io_hit_q  <= io_hit_d;
            mem_hit_q <= mem_hit_d;
            rom_hit_q <= rom_hit_d;
            idx_q     <= idx_d;
            master_q  <= master_d;
        end
    end

    // Latency counter hookup
    assign lat.lat_value = lat_q[LAT_LSB+LAT_W-1:LAT_LSB];
    assign lat.frame_drv = i_frame_drv;
    assign lat.gnt_n     = i_gnt_n;
    assign lat.soft_rst  = i_soft_rst;

    pcr_lat_timer #(
        .LAT_W (LAT_W)
    ) u_lat (
        .i_ref_clk (i_ref_clk),
        .i_srst    (i_srst),
        .lat       (lat.timer)
    );

    // Outputs straight from flip-flops
    assign o_cfg_rdata     = rdata_q;
    assign o_cfg_ack       = ack_q;
    assign o_io_hit        = io_hit_q;
    assign o_mem_hit       = mem_hit_q;
    assign o_rom_hit       = rom_hit_q;
    assign o_csr_index     = idx_q;
    assign o_master_en     = master_q;
    assign o_lat_terminate = lat.terminate;
    assign o_lat_expired   = lat.expired;

endmodule : pcr_cfg_regs

// ===== sim/pcr_cfg_regs_properties.sv
`timescale 1ns/10ps
module pcr_cfg_regs_chk
    import pcr_pkg::*;
(
    input wire logic        i_ref_clk,
    input wire logic        i_srst,
    input wire logic        i_soft_rst,
    input wire logic        i_cfg_sel,
    input wire logic        i_cfg_we,
    input wire logic [7:0]  i_cfg_addr,
    input wire logic [3:0]  i_cfg_be,
    input wire logic [31:0] i_cfg_wdata,
    input wire logic [31:0] o_cfg_rdata,
    input wire logic        o_cfg_ack,
    input wire logic        i_io_req,
    input wire logic        i_mem_req,
    input wire logic        o_io_hit,
    input wire logic        o_mem_hit,
    input wire logic        o_rom_hit,
    input wire logic        i_gnt_n,
    input wire logic        i_frame_drv,
    input wire logic        o_lat_terminate,
    input wire logic        o_lat_expired
);
    logic       io_en_q, mem_en_q, rom_en_q, rd_q;
    logic [7:0] adr_q;
    wire        wr0 = i_cfg_sel && i_cfg_we && i_cfg_be[0];
    // Mirror of decode enables and of the last read target
    always_ff @(posedge i_ref_clk) begin
        io_en_q  <= i_srst ? 1'b0 : (wr0 && i_cfg_addr == CFG_CMD_OFF) ? i_cfg_wdata[0] : io_en_q;
        mem_en_q <= i_srst ? 1'b0 : (wr0 && i_cfg_addr == CFG_CMD_OFF) ? i_cfg_wdata[1] : mem_en_q;
        rom_en_q <= i_srst ? 1'b0 : (wr0 && i_cfg_addr == CFG_ROMB_OFF) ? i_cfg_wdata[0]
                    : rom_en_q;
        rd_q     <= !i_srst && i_cfg_sel && !i_cfg_we;
        adr_q    <= i_cfg_addr;
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);
    a_ack_follows_sel: assert property (i_cfg_sel |=> o_cfg_ack)
        else $error("no ack after access");
    a_iob_low_bits: assert property (o_cfg_ack && rd_q && adr_q == CFG_IOB_OFF
        |-> o_cfg_rdata[6:0] == 7'h01) else $error("io base low bits wrong");
    a_memb_low_bits: assert property (o_cfg_ack && rd_q && adr_q == CFG_MEMB_OFF
        |-> o_cfg_rdata[6:0] == 7'h00) else $error("mem base low bits wrong");
    a_rom_fixed_zero: assert property (o_cfg_ack && rd_q && adr_q == CFG_ROMB_OFF
        |-> o_cfg_rdata[17:1] == 17'h0_0000) else $error("rom base fixed bits wrong");
    a_io_hit_cause: assert property (o_io_hit
        |-> $past(i_io_req) && $past(io_en_q) && !$past(i_soft_rst)) else $error("bad io hit");
    a_mem_hit_cause: assert property (o_mem_hit
        |-> $past(i_mem_req) && $past(mem_en_q) && !$past(i_soft_rst)) else $error("bad mem hit");
    a_rom_hit_cause: assert property (o_rom_hit
        |-> $past(i_mem_req) && $past(mem_en_q) && $past(rom_en_q)) else $error("bad rom hit");
    a_term_cause: assert property ($rose(o_lat_terminate)
        |-> $past(o_lat_expired) && $past(i_gnt_n)) else $error("termination without cause");
    a_exp_in_frame: assert property (o_lat_expired
        |-> $past(i_frame_drv) || $past(i_frame_drv, 2)) else $error("expiry outside frame");
    c_rom_hit: cover property (o_rom_hit);
    c_terminate: cover property ($rose(o_lat_terminate));
    c_io_hit: cover property (o_io_hit);
endmodule : pcr_cfg_regs_chk
bind pcr_cfg_regs pcr_cfg_regs_chk u_chk (.i_ref_clk, .i_srst, .i_soft_rst, .i_cfg_sel,
    .i_cfg_we, .i_cfg_addr, .i_cfg_be, .i_cfg_wdata, .o_cfg_rdata, .o_cfg_ack, .i_io_req,
    .i_mem_req, .o_io_hit, .o_mem_hit, .o_rom_hit, .i_gnt_n, .i_frame_drv,
    .o_lat_terminate, .o_lat_expired);

// ===== sim/pcr_host_bfm.sv
`timescale 1ns/10ps
module pcr_host_bfm (
    input  wire logic        i_ref_clk,
    input  wire logic        i_cfg_ack,
    input  wire logic [31:0] i_cfg_rdata,
    output logic             o_cfg_sel = 1'b0,
    output logic             o_cfg_we = 1'b0,
    output logic [7:0]       o_cfg_addr = 8'h00,
    output logic [3:0]       o_cfg_be = 4'h0,
    output logic [31:0]      o_cfg_wdata = 32'h0000_0000
);
    // One configuration cycle; released lines show inverted values
    task automatic cfg(input logic we, input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] wd, output logic [31:0] rd, output logic ack);
        @(posedge i_ref_clk);
        o_cfg_sel   <= 1'b1;
        o_cfg_we    <= we;
        o_cfg_addr  <= a;
        o_cfg_be    <= be;
        o_cfg_wdata <= wd;
        @(posedge i_ref_clk);
        o_cfg_sel   <= 1'b0;
        o_cfg_we    <= ~we;
        o_cfg_addr  <= ~a;
        o_cfg_be    <= ~be;
        o_cfg_wdata <= ~wd;
        @(negedge i_ref_clk);
        rd  = i_cfg_rdata;
        ack = i_cfg_ack;
    endtask : cfg
endmodule : pcr_host_bfm

// ===== sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import pcr_pkg::*;
    logic        i_ref_clk = 1'b0, i_srst = 1'b1, i_soft_rst = 1'b0, i_srom_valid = 1'b0;
    logic        i_srom_ok = 1'b0, i_io_req = 1'b0, i_mem_req = 1'b0, i_frame_drv = 1'b0;
    logic        i_gnt_n = 1'b0, i_cfg_sel, i_cfg_we, o_cfg_ack, o_io_hit, o_mem_hit;
    logic        o_rom_hit, o_master_en, o_lat_terminate, o_lat_expired, ack;
    logic [3:0]  i_cfg_be, o_csr_index;
    logic [7:0]  i_cfg_addr, a;
    logic [31:0] i_srom_data = 32'h0000_0000, i_io_addr = 32'h0000_0000, rd;
    logic [31:0] i_mem_addr = 32'h0000_0000, i_cfg_wdata, o_cfg_rdata, mdl [0:15];
    logic [7:0]  offs [0:7] = '{CFG_CMD_OFF, CFG_LAT_OFF, CFG_IOB_OFF, CFG_MEMB_OFF,
                                CFG_SUBSYSTEM_IDENTIFICATION_OFF, CFG_ROMB_OFF, CFG_INTR_OFF, 8'h40};
    int          seed = 32'h42b2_289f, err_count = 0, tests_run = 0, cyc = 0, n, k;
    pcr_cfg_regs dut (.i_ref_clk, .i_srst, .i_soft_rst, .i_cfg_sel, .i_cfg_we, .i_cfg_addr,
        .i_cfg_be, .i_cfg_wdata, .o_cfg_rdata, .o_cfg_ack, .i_srom_valid, .i_srom_ok,
        .i_srom_data, .i_io_req, .i_io_addr, .i_mem_req, .i_mem_addr, .o_io_hit, .o_mem_hit,
        .o_rom_hit, .o_csr_index, .i_frame_drv, .i_gnt_n, .o_master_en, .o_lat_terminate,
        .o_lat_expired);
    pcr_host_bfm host (.i_ref_clk, .i_cfg_ack(o_cfg_ack), .i_cfg_rdata(o_cfg_rdata),
        .o_cfg_sel(i_cfg_sel), .o_cfg_we(i_cfg_we), .o_cfg_addr(i_cfg_addr),
        .o_cfg_be(i_cfg_be), .o_cfg_wdata(i_cfg_wdata));
    // Clock and hang limit
    initial begin
        forever #20 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            err_count = err_count + 1;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Write updates the model through lanes and writable bits; read compares
    task automatic acc(input logic we, input logic [7:0] ad, input logic [3:0] be,
                       input logic [31:0] wd);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        case (ad)
            CFG_CMD_OFF:               m = m & CMD_WMASK;
            CFG_LAT_OFF:               m = m & LAT_WMASK;
            CFG_IOB_OFF, CFG_MEMB_OFF: m = m & BAR_WMASK;
            CFG_ROMB_OFF:              m = m & ROM_WMASK;
            CFG_INTR_OFF:              m = m & INTR_WMASK;
            default:                   m = 32'h0000_0000;
        endcase
        host.cfg(we, ad, be, wd, rd, ack);
        if (we) mdl[ad[5:2]] = (mdl[ad[5:2]] & ~m) | (wd & m);
        else chk(rd, mdl[ad[5:2]]);
        chk(32'(ack), 32'h1);
    endtask : acc
    task automatic dec(input logic io, input logic [31:0] ad);
        @(posedge i_ref_clk);
        i_io_req   <= io;
        i_mem_req  <= !io;
        i_io_addr  <= ad;
        i_mem_addr <= ad;
        @(posedge i_ref_clk);
        i_io_req   <= 1'b0;
        i_mem_req  <= 1'b0;
        i_io_addr  <= ~ad;
        i_mem_addr <= ~ad;
        @(negedge i_ref_clk);
    endtask : dec
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    // Main sequence
    initial begin
        for (int j = 0; j < 2; j++) begin
            repeat (4) @(posedge i_ref_clk);
            i_srst <= 1'b0;
            foreach (mdl[i]) mdl[i] = 32'h0000_0000;
            mdl[1]  = STATUS_FIXED;
            mdl[4]  = IO_INDICATOR;
            mdl[15] = INTR_RESET;
            for (int i = 0; i < 8; i++) acc(1'b0, offs[i], 4'hf, 32'h0);
            i_srom_valid <= 1'b1;
            i_srom_ok    <= j[0];
            i_srom_data  <= $random(seed);
            @(posedge i_ref_clk);
            i_srom_valid <= 1'b0;
            mdl[11] = (j == 1) ? i_srom_data : 32'h0000_0000;
            @(posedge i_ref_clk);
            i_srom_valid <= 1'b1;
            i_srom_ok    <= 1'b1;
            i_srom_data  <= ~i_srom_data;
            @(posedge i_ref_clk);
            i_srom_valid <= 1'b0;
            acc(1'b1, CFG_SUBSYSTEM_IDENTIFICATION_OFF, 4'hf, 32'hffff_ffff);
            acc(1'b0, CFG_SUBSYSTEM_IDENTIFICATION_OFF, 4'hf, 32'h0);
            $display("test reset and serial load %0d done", j);
            i_srst <= (j == 0);
        end
        for (int i = 0; i < 68; i++) begin
            a = (i < 8) ? offs[i] : offs[$unsigned($random(seed)) % 8];
            acc(1'b1, a, (i < 8) ? 4'hf : 4'($random(seed)), (i < 8) ? '1 : $random(seed));
            acc(1'b0, a, 4'hf, 32'h0);
        end
        $display("test register access done");
        acc(1'b1, CFG_IOB_OFF, 4'hf, $random(seed));
        acc(1'b1, CFG_MEMB_OFF, 4'hf, $random(seed));
        for (int c = 0; c < 8; c++) begin
            acc(1'b1, CFG_CMD_OFF, 4'h1, 32'(c));
            acc(1'b1, CFG_ROMB_OFF, 4'hf, {31'($random(seed)), c[2]});
            chk(32'(o_master_en), 32'(c[2]));
            k = (c == 0) ? 15 : $unsigned($random(seed)) % 16;
            dec(1'b1, {mdl[4][31:7], k[3:0], 3'h0});
            chk(32'({o_io_hit, o_csr_index}), 32'({c[0], c[0] ? k[3:0] : 4'h0}));
            dec(1'b0, {mdl[5][31:7], k[3:0], 3'h0});
            chk(32'({o_mem_hit, o_csr_index}), 32'({c[1], c[1] ? k[3:0] : 4'h0}));
            dec(1'b0, {mdl[12][31:18], 18'($random(seed))});
            chk(32'(o_rom_hit), 32'(c[1] & c[2]));
            dec(1'b1, {mdl[4][31:7] + 25'h1, 7'h00});
            chk(32'(o_io_hit), 32'h0);
        end
        i_soft_rst <= 1'b1;
        dec(1'b1, {mdl[4][31:7], 7'h08});
        chk(32'(o_io_hit), 32'h0);
        i_soft_rst <= 1'b0;
        acc(1'b0, CFG_ROMB_OFF, 4'hf, 32'h0);
        $display("test decode done");
        for (int i = 0; i < 6; i++) begin
            n = (i < 2) ? i : (i == 2) ? 255 : 2 + $unsigned($random(seed)) % 40;
            acc(1'b1, CFG_LAT_OFF, 4'h2, 32'(n) << 8);
            n = n + 1; // Registered expiry lags the loaded count by one
            @(posedge i_ref_clk);
            i_frame_drv <= 1'b1;
            i_gnt_n     <= (i == 5);
            repeat (n - 1) @(posedge i_ref_clk);
            @(negedge i_ref_clk);
            chk(32'(o_lat_expired), 32'h0);
            if (i == 5) i_frame_drv <= 1'b0;
            @(negedge i_ref_clk);
            chk(32'({o_lat_expired, o_lat_terminate}), (i == 5) ? 32'h0 : 32'h2);
            @(posedge i_ref_clk);
            i_gnt_n <= 1'b1;
            @(negedge i_ref_clk);
            chk(32'(o_lat_terminate), 32'h0);
            @(negedge i_ref_clk);
            chk(32'(o_lat_terminate), 32'(i != 5));
            i_frame_drv <= 1'b0;
            i_gnt_n     <= 1'b0;
            repeat (3) @(posedge i_ref_clk);
        end
        $display("test latency timer done");
        stop_test();
    end
endmodule : tb_top
